// [sram_host_ctrl.sv]
// Purpose: host side controller driving an asynchronous 524288 x 8 static memory
// Assumes: memory pins sampled synchronously to clk; one access at a time
// Notes:   writes are strobe controlled; select falls with the strobe so data
//          outputs never turn on during a write
//          a power down request that arrives mid access lets that access finish,
//          so power_down must rise one full access before the supply starts to drop
//          the recovery hold is RECOVERY_CYCLES clocks of select high after power returns
//          and a new dip during the hold restarts the whole count

module sram_host_ctrl #(
  parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYC
) (
  input  wire logic                            clk,
  input  wire logic                            rst,
  // user side
  input  wire logic                            req_valid,
  input  wire sram_host_pkg::sram_req_t        req,
  output logic                                 req_ready,
  output logic                                 rsp_valid,
  output logic [sram_host_pkg::DATA_W-1:0]     rsp_rdata,
  input  wire logic                            power_down,
  output logic                                 recovering,
  // memory side
  output logic [sram_host_pkg::ADDR_W-1:0]     mem_addr,
  output sram_host_pkg::sram_ctrl_t            mem_ctrl,
  input  wire logic [sram_host_pkg::DATA_W-1:0] data_lines_in,
  output logic [sram_host_pkg::DATA_W-1:0]     data_lines_out,
  output logic                                 data_lines_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_RECOVER, S_IDLE, S_WRITE, S_WHOLD, S_READ, S_TURN, S_DOWN
  } state_t;
  // recover is also the reset state, so the power-up hold runs after every reset

  state_t                           state_q, state_d;
  logic [sram_host_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [sram_host_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [sram_host_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  sram_host_pkg::sram_ctrl_t        ctrl_q, ctrl_d;
  logic                             oe_n_q, oe_n_d;
  logic                             ready_q, ready_d, rvalid_q, rvalid_d, recov_q, recov_d;

  function automatic logic [sram_host_pkg::CNT_W-1:0] cyc(input int n);
    cyc = sram_host_pkg::CNT_W'(n - 1);
  endfunction : cyc

  wire cnt_done = (cnt_q == '0);
  // a request is taken only in idle and only while power is steady
  wire take     = ready_q && req_valid && !power_down;

  // ----------------------------------------------------------------
  // control codes and counter loads
  // ----------------------------------------------------------------
  // field order is select, strobe, output enable, all active low
  localparam sram_host_pkg::sram_ctrl_t CTRL_IDLE  = '{1'b1, 1'b1, 1'b1};
  // select and strobe fall together so the memory never turns its drivers on
  localparam sram_host_pkg::sram_ctrl_t CTRL_WRITE = '{1'b0, 1'b0, 1'b1};
  // strobe rises ahead of select so the strobe edge is the capturing one
  localparam sram_host_pkg::sram_ctrl_t CTRL_WEND  = '{1'b0, 1'b1, 1'b1};
  localparam sram_host_pkg::sram_ctrl_t CTRL_READ  = '{1'b0, 1'b1, 1'b0};
  // plain constant so the asynchronous reset branch loads nothing computed
  localparam logic [sram_host_pkg::CNT_W-1:0] RECOV_LOAD = sram_host_pkg::CNT_W'(RECOVERY_CYCLES - 1);

  wire [sram_host_pkg::CNT_W-1:0] load_wpulse = cyc(sram_host_pkg::WPULSE_CYC);
  wire [sram_host_pkg::CNT_W-1:0] load_whold  = cyc(sram_host_pkg::CYCLE_CYC - sram_host_pkg::WPULSE_CYC);
  wire [sram_host_pkg::CNT_W-1:0] load_access = cyc(sram_host_pkg::ACCESS_CYC);
  wire [sram_host_pkg::CNT_W-1:0] load_turn   = cyc(sram_host_pkg::DIS_CYC);

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_done ? cnt_q : cnt_q - 1'b1;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    ctrl_d   = ctrl_q;
    oe_n_d   = oe_n_q;
    ready_d  = 1'b0;
    rvalid_d = 1'b0;
    recov_d  = recov_q;
    case (state_q)
      S_RECOVER: begin
        ctrl_d  = CTRL_IDLE;
        recov_d = 1'b1;
        // a supply dip during the hold restarts the full count
        if (power_down) begin
          cnt_d = RECOV_LOAD;
        end else if (cnt_done) begin
          state_d = S_IDLE;
          recov_d = 1'b0;
          ready_d = 1'b1;
        end
      end
      S_IDLE: begin
        // power down wins over a request presented in the same cycle
        ready_d = !power_down;
        ctrl_d  = CTRL_IDLE;
        oe_n_d  = 1'b1;
        if (power_down) begin
          state_d = S_DOWN;
          ready_d = 1'b0;
        end else if (take) begin
          ready_d = 1'b0;
          addr_d  = req.addr;
          if (req.write) begin
            wdata_d = req.wdata;
            state_d = S_WRITE;
            cnt_d   = load_wpulse;
            ctrl_d  = CTRL_WRITE;
            oe_n_d  = 1'b0;
          end else begin
            state_d = S_READ;
            cnt_d   = load_access;
            ctrl_d  = CTRL_READ;
          end
        end
      end
      S_WRITE: if (cnt_done) begin
        // strobe rises first while data and address still stand
        ctrl_d  = CTRL_WEND;
        state_d = S_WHOLD;
        cnt_d   = load_whold;
      end
      S_WHOLD: begin
        // bus released together with select, one clock after the strobe edge
        ctrl_d = CTRL_IDLE;
        oe_n_d = 1'b1;
        if (cnt_done) begin
          state_d = S_IDLE;
          ready_d = 1'b1;
        end
      end
      S_READ: if (cnt_done) begin
        // data is taken while select and enable still stand
        rdata_d  = data_lines_in;
        rvalid_d = 1'b1;
        ctrl_d   = CTRL_IDLE;
        state_d  = S_TURN;
        cnt_d    = load_turn;
      end
      S_TURN: if (cnt_done) begin
        // memory drivers have had their disable time before anyone drives
        state_d = S_IDLE;
        ready_d = 1'b1;
      end
      S_DOWN: begin
        // parked deselected until power is reported back; nothing is accepted
        ctrl_d = CTRL_IDLE;
        oe_n_d = 1'b1;
        if (!power_down) begin
          state_d = S_RECOVER;
          cnt_d   = RECOV_LOAD;
          recov_d = 1'b1;
        end
      end
      default: state_d = S_RECOVER;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // every control idles high in reset so the memory sits deselected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= S_RECOVER;
      cnt_q    <= RECOV_LOAD;
      addr_q   <= '0;
      wdata_q  <= '0;
      rdata_q  <= '0;
      ctrl_q   <= CTRL_IDLE;
      oe_n_q   <= 1'b1;
      ready_q  <= 1'b0;
      rvalid_q <= 1'b0;
      recov_q  <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      ctrl_q   <= ctrl_d;
      oe_n_q   <= oe_n_d;
      ready_q  <= ready_d;
      rvalid_q <= rvalid_d;
      recov_q  <= recov_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every pin comes from a register so the memory never sees a glitch
  assign req_ready       = ready_q;
  assign rsp_valid       = rvalid_q;
  assign rsp_rdata       = rdata_q;
  assign recovering      = recov_q;
  assign mem_addr        = addr_q;
  assign mem_ctrl        = ctrl_q;
  assign data_lines_out  = wdata_q;
  assign data_lines_oe_n = oe_n_q;

endmodule : sram_host_ctrl

// [sram_host_pkg.sv]
// Purpose: shared constants and carrier types for the static memory host controller
// Assumes: 100 MHz clock, 524288 x 8 asynchronous static memory on the far side
// Notes:   timing figures are the slowest speed grade so one build serves all grades
package sram_host_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;

  // access timing in ns, recovery in ms, slowest grade
  localparam int T_CYCLE_NS = 100;
  localparam int T_WPULSE_NS = 80;
  localparam int T_ACCESS_NS = 100;
  localparam int T_DIS_NS = 35;
  localparam int T_RECOVERY_MS = 5;

  // least times round up
  localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int DIS_CYC = (T_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC = T_RECOVERY_MS * 1000000 / CLK_PERIOD_NS;

  localparam int CNT_W = 20;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;

  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_enable_n;
  } sram_ctrl_t;

endpackage : sram_host_pkg

// [sram_host_monitor.sv]
// Purpose: host side checks on the memory pins
// Assumes: bound to sram_host_ctrl, one clock
// Notes:   device behaviour is judged by the bench, not here
module sram_host_monitor #(
  parameter int RECOVERY_CYCLES = sram_host_pkg::RECOVERY_CYC
) (
  input wire logic                             clk,
  input wire logic                             rst,
  input wire logic                             req_ready,
  input wire logic                             power_down,
  input wire logic                             recovering,
  input wire logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
  input wire sram_host_pkg::sram_ctrl_t        mem_ctrl,
  input wire logic [sram_host_pkg::DATA_W-1:0] data_lines_out,
  input wire logic                             data_lines_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  wire wr_on = !mem_ctrl.chip_select_n && !mem_ctrl.write_strobe_n;
  wire rd_on = !mem_ctrl.chip_select_n && mem_ctrl.write_strobe_n && !mem_ctrl.output_enable_n;
  int unsigned hold_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_q <= 0;
    else hold_q <= recovering ? hold_q + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_end; $fell(wr_on); endsequence
  property p_addr_hold; wr_on && $past(wr_on) |-> $stable(mem_addr); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_data_hold; s_wr_end |-> $stable(data_lines_out) && !data_lines_oe_n; endproperty
  a_data_hold: assert property (p_data_hold) else $error("write data not held");
  property p_no_fight; rd_on |-> data_lines_oe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");
  property p_down; power_down && req_ready |=> mem_ctrl.chip_select_n && !req_ready; endproperty
  a_down: assert property (p_down) else $error("select low at power down");
  property p_rec_sel; recovering |-> mem_ctrl.chip_select_n && !req_ready; endproperty
  a_rec_sel: assert property (p_rec_sel) else $error("access during recovery");
  property p_rec_len; $fell(recovering) |-> hold_q >= RECOVERY_CYCLES; endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery too short");
endmodule : sram_host_monitor
bind sram_host_ctrl sram_host_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) i_sram_host_monitor (
  .clk(clk), .rst(rst), .req_ready(req_ready), .power_down(power_down), .recovering(recovering),
  .mem_addr(mem_addr), .mem_ctrl(mem_ctrl), .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));

// [sram_device_model.sv]
// Purpose: behavioural static memory on the far side
// Assumes: host data bus split into data, enable and read back
// Notes:   clk only paces the floating-bus pattern
module sram_device_model (
  input wire logic                             clk,
  input wire logic [sram_host_pkg::ADDR_W-1:0] addr,
  input wire sram_host_pkg::sram_ctrl_t        ctrl,
  input wire logic [sram_host_pkg::DATA_W-1:0] host_d,
  input wire logic                             host_oe_n,
  output logic [sram_host_pkg::DATA_W-1:0]     bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cell_q [0:524287];
  logic [7:0] float_q = 8'h5a;
  wire wr_on = !ctrl.chip_select_n && !ctrl.write_strobe_n;
  wire rd_on = !ctrl.chip_select_n && ctrl.write_strobe_n && !ctrl.output_enable_n;
  // data shows only after the access time, so an early sample reads the floating pattern
  wire #(sram_host_pkg::T_ACCESS_NS) rd_late = rd_on;
  logic wr_seen = 1'b0;
  // no pull on the bus, so an undriven bus keeps changing
  always @(posedge clk) float_q <= ~float_q;
  // first rising control ends a real overlap and latches the byte; reset settling is no write
  always @(wr_on) begin
    if (wr_seen && wr_on !== 1'b1) cell_q[addr] <= bus;
    wr_seen = (wr_on === 1'b1);
  end
  assign bus = !host_oe_n ? host_d : (rd_on && rd_late) ? cell_q[addr] : float_q;
endmodule : sram_device_model

// [test_async_sram_access_port.sv]
// Purpose: self-checking bench for sram_host_ctrl
// Assumes: recovery shortened to RC cycles
// Notes:   inputs change 1 ns after the rising edge
module test_async_sram_access_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RC = 20;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, power_down = 1'b0;
  logic req_ready, rsp_valid, recovering, data_lines_oe_n;
  logic [7:0] rsp_rdata, data_lines_in, data_lines_out;
  logic [18:0] mem_addr;
  sram_host_pkg::sram_req_t req = '0;
  sram_host_pkg::sram_ctrl_t mem_ctrl;
  int failures = 0, n_checks = 0;
  always #5 clk = ~clk;
  sram_host_ctrl #(.RECOVERY_CYCLES(RC)) i_sram_host_ctrl (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .power_down(power_down),
    .recovering(recovering), .mem_addr(mem_addr), .mem_ctrl(mem_ctrl), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
  sram_device_model i_sram_device_model (.clk(clk), .addr(mem_addr), .ctrl(mem_ctrl),
    .host_d(data_lines_out), .host_oe_n(data_lines_oe_n), .bus(data_lines_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic tick(); @(posedge clk); #1; endtask : tick
  task automatic hold_wait(output int n, output logic bad);
    n = 0;
    bad = 1'b0;
    while (req_ready !== 1'b1 && n < 200) begin
      if (mem_ctrl.chip_select_n !== 1'b1) bad = 1'b1;
      tick();
      n++;
    end
    chk("ready_timeout", 0, n >= 200);
  endtask : hold_wait
  task automatic acc(input logic w, input logic [18:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    logic bad;
    hold_wait(n, bad);
    req = '{w, a, d};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1 && n < 30) begin tick(); n++; end
    if (!w) chk("rsp_timeout", 0, n >= 30);
    q = rsp_rdata;
  endtask : acc
  task automatic t_boot();
    int n;
    logic bad;
    chk("boot_recov", 1, recovering);
    hold_wait(n, bad);
    chk("boot_hold", 1, n >= RC && !bad);
    chk("boot_recov_end", 0, recovering);
    $display("test boot done");
  endtask : t_boot
  task automatic t_rw();
    logic [7:0] q;
    acc(1, 19'h00000, 8'h96, q);
    acc(1, 19'h7ffff, 8'h3c, q);
    acc(1, 19'h00055, 8'hc3, q);
    acc(1, 19'h00055, 8'h7e, q);
    acc(0, 19'h7ffff, 8'h00, q);
    chk("rd_top", 8'h3c, q);
    acc(0, 19'h00000, 8'h00, q);
    chk("rd_low", 8'h96, q);
    acc(0, 19'h00000, 8'h00, q);
    chk("rd_again", 8'h96, q);
    acc(0, 19'h00055, 8'h00, q);
    chk("rd_over", 8'h7e, q);
    $display("test read write done");
  endtask : t_rw
  task automatic t_power();
    int n;
    logic bad;
    logic [7:0] q;
    hold_wait(n, bad);
    power_down = 1'b1;
    req = '{1'b1, 19'h00055, 8'hff};
    req_valid = 1'b1;
    repeat (5) tick();
    chk("down_sel", 1, mem_ctrl.chip_select_n);
    chk("down_ready", 0, req_ready);
    req_valid = 1'b0;
    power_down = 1'b0;
    repeat (3) tick();
    chk("up_recov", 1, recovering);
    power_down = 1'b1;
    tick();
    power_down = 1'b0;
    hold_wait(n, bad);
    chk("up_hold", 1, n >= RC && !bad);
    acc(0, 19'h00055, 8'h00, q);
    chk("rd_kept", 8'h7e, q);
    $display("test power done");
  endtask : t_power
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_boot();
    t_rw();
    t_power();
    give_verdict();
  end
  initial begin
    #50us;
    failures++;
    give_verdict();
  end
endmodule : test_async_sram_access_port
